/* File: hdl/scl_consts.svh */
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH
`define SCL_OFF_RX_WORD 8'h00
`define SCL_OFF_TX_WORD 8'h04
`define SCL_OFF_AUX_WORD 8'h08
`define SCL_OFF_STATUS 8'h0C
`define SCL_OFF_IRQ_STAT 8'h10
`define SCL_OFF_IRQ_CLR 8'h14
`define SCL_OFF_IRQ_EN 8'h18
`define SCL_RX_WORD_RST 22'h000040
`define SCL_TX_WORD_RST 22'h000040
`define SCL_AUX_WORD_RST 22'h000000
`define SCL_DIV_MIN 17'h00040
`define SCL_DIV_LSB 0
`define SCL_DIV_MSB 16
`define SCL_BAND_BIT 17
`define SCL_OSC_CUR_LSB 18
`define SCL_PD_POL_BIT 20
`define SCL_GAIN_SRC_BIT 21
`define SCL_UNLOCK_TH_LSB 17
`define SCL_LOCK_TH_LSB 19
`define SCL_MOD_SRC_BIT 21
`define SCL_INT_GAIN_BIT 12
`define SCL_INT_MOD_BIT 19
`define SCL_IRQ_LOCK_RISE 0
`define SCL_IRQ_LOCK_FALL 1
`define SCL_IRQ_DIV_BAD 2
`define SCL_CLK_FREQ_KHZ 125000
`define SCL_REF_FREQ_KHZ 12500
`define SCL_REF_DIV (`SCL_CLK_FREQ_KHZ / `SCL_REF_FREQ_KHZ)
`define SCL_UNLOCK_TH0 5'h02
`define SCL_UNLOCK_TH1 5'h04
`define SCL_UNLOCK_TH2 5'h08
`define SCL_UNLOCK_TH3 5'h10
`define SCL_LOCK_TH0 9'h004
`define SCL_LOCK_TH1 9'h010
`define SCL_LOCK_TH2 9'h040
`define SCL_LOCK_TH3 9'h100
`endif

/* File: hdl/scl_pkg.sv */
package scl_pkg;
  `include "scl_consts.svh"

  typedef enum logic [1:0] {
    SCL_ST_UNLOCKED = 2'b01,
    SCL_ST_LOCKED = 2'b10
  } scl_lock_state_t;

  typedef struct packed {
    scl_lock_state_t state;
    logic [4:0] ucnt;
    logic [8:0] lcnt;
    logic rise;
    logic fall;
  } scl_det_t;

  typedef struct packed {
    logic [21:0] rx_word;
    logic [21:0] tx_word;
    logic [21:0] aux_word;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [31:0] rdata;
    logic [2:0] gain_s;
    logic [2:0] mod_s;
    logic [2:0] up_s;
    logic [2:0] dn_s;
    logic gain_f;
    logic mod_f;
    logic up_f;
    logic dn_f;
    logic [3:0] ref_cnt;
    logic ref_tick;
    logic [16:0] div_out;
    logic band;
    logic [1:0] osc_cur;
    logic pd_pol;
    logic amp_gain;
    logic mod_sel;
    logic lock;
    logic irq;
  } scl_core_t;

  function automatic logic [4:0] scl_unlock_limit(input logic [1:0] c);
    case (c)
      2'h0: return `SCL_UNLOCK_TH0;
      2'h1: return `SCL_UNLOCK_TH1;
      2'h2: return `SCL_UNLOCK_TH2;
      default: return `SCL_UNLOCK_TH3;
    endcase
  endfunction : scl_unlock_limit

  function automatic logic [8:0] scl_lock_limit(input logic [1:0] c);
    case (c)
      2'h0: return `SCL_LOCK_TH0;
      2'h1: return `SCL_LOCK_TH1;
      2'h2: return `SCL_LOCK_TH2;
      default: return `SCL_LOCK_TH3;
    endcase
  endfunction : scl_lock_limit
endpackage : scl_pkg

/* File: hdl/scl_lock_if.sv */
`timescale 1ns/1ns
interface scl_lock_if;
  logic ref_tick;
  logic pd_err;
  logic [1:0] unlock_code;
  logic [1:0] lock_code;
  logic locked;
  logic lock_rise;
  logic lock_fall;
  modport core (
    output ref_tick, pd_err, unlock_code, lock_code,
    input locked, lock_rise, lock_fall
  );
  modport det (
    input ref_tick, pd_err, unlock_code, lock_code,
    output locked, lock_rise, lock_fall
  );
endinterface : scl_lock_if

/* File: hdl/scl_lock_detect.sv */
`timescale 1ns/1ns
module scl_lock_detect
  import scl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  scl_lock_if.det lk
);
  scl_det_t st_reg;
  scl_det_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (lk.ref_tick) begin
      if (lk.pd_err) begin
        st_next.lcnt = 9'h000;
        if (st_reg.ucnt != 5'h1F) begin
          st_next.ucnt = st_reg.ucnt + 5'h01;
        end
        if (st_next.ucnt >= scl_unlock_limit(lk.unlock_code)) begin
          if (st_reg.state == SCL_ST_LOCKED) begin
            st_next.fall = 1'b1;
          end
          st_next.state = SCL_ST_UNLOCKED;
        end
      end else begin
        st_next.ucnt = 5'h00;
        case (st_reg.state)
          SCL_ST_UNLOCKED: begin
            st_next.lcnt = st_reg.lcnt + 9'h001;
            if (st_next.lcnt >= scl_lock_limit(lk.lock_code)) begin
              st_next.state = SCL_ST_LOCKED;
              st_next.rise = 1'b1;
              st_next.lcnt = 9'h000;
            end
          end
          SCL_ST_LOCKED: begin
            st_next.lcnt = 9'h000;
          end
          default: begin
            st_next.state = SCL_ST_UNLOCKED;
            st_next.lcnt = 9'h000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{state: SCL_ST_UNLOCKED, ucnt: 5'h00, lcnt: 9'h000,
                  rise: 1'b0, fall: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lk.locked = (st_reg.state == SCL_ST_LOCKED);
  assign lk.lock_rise = st_reg.rise;
  assign lk.lock_fall = st_reg.fall;
endmodule : scl_lock_detect

/* File: hdl/scl_synth_cfg.sv */
// What this block does
// - The receive word's low 17 bits are the receive feedback divider, 64 to 131071.
// - The transmit word's low 17 bits are the transmit feedback divider, 64 to 131071.
// - Receive word bit 17 selects the band, below or above 500 MHz.
// - Receive word bits 19:18 pick one of four rising oscillator currents.
// - Receive word bit 20 sets phase detector polarity, 0 negative by default.
// - With receive word bit 21 at 0 the amplifier gain follows the gain pin.
// - With receive word bit 21 at 1 the gain follows auxiliary bit 12.
// - Transmit bits 18:17 set 2, 4, 8 or 16 error reference ticks (one every 10th clock) before unlock.
// - Transmit bits 20:19 set 4, 16, 64 or 256 clean reference ticks (one every 10th clock) before lock.
// - With transmit word bit 21 at 1 modulation follows auxiliary bit 19.
`timescale 1ns/1ns
`include "scl_consts.svh"
module scl_synth_cfg
  import scl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_tx_mode,
  input wire logic i_ext_amp_gain_pin,
  input wire logic i_ext_mod_sel_pin,
  input wire logic i_pd_up,
  input wire logic i_pd_down,
  output logic [16:0] o_feedback_divider,
  output logic o_band_select,
  output logic [1:0] o_osc_current,
  output logic o_pd_polarity,
  output logic o_amp_gain,
  output logic o_modulation_sel,
  output logic o_lock,
  output logic o_irq
);
  localparam logic [3:0] REF_LAST = 4'(`SCL_REF_DIV - 1);

  scl_core_t st_reg;
  scl_core_t st_next;
  scl_lock_if lk ();

  // A pin level is taken only once the last two stages agree.
  function automatic logic sync_filt(input logic [2:0] s,
                                     input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction : sync_filt

  function automatic logic div_bad(input logic [31:0] d);
    return d[`SCL_DIV_MSB:`SCL_DIV_LSB] < `SCL_DIV_MIN;
  endfunction : div_bad

  scl_lock_detect u_det (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .lk(lk)
  );

  assign lk.ref_tick = st_reg.ref_tick;
  assign lk.pd_err = st_reg.up_f | st_reg.dn_f;
  assign lk.unlock_code = st_reg.tx_word[`SCL_UNLOCK_TH_LSB +: 2];
  assign lk.lock_code = st_reg.tx_word[`SCL_LOCK_TH_LSB +: 2];

  always_comb begin
    logic [2:0] ev;
    ev = 3'h0;
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;

    st_next.gain_s = {st_reg.gain_s[1:0], i_ext_amp_gain_pin};
    st_next.mod_s = {st_reg.mod_s[1:0], i_ext_mod_sel_pin};
    st_next.up_s = {st_reg.up_s[1:0], i_pd_up};
    st_next.dn_s = {st_reg.dn_s[1:0], i_pd_down};
    st_next.gain_f = sync_filt(st_reg.gain_s, st_reg.gain_f);
    st_next.mod_f = sync_filt(st_reg.mod_s, st_reg.mod_f);
    st_next.up_f = sync_filt(st_reg.up_s, st_reg.up_f);
    st_next.dn_f = sync_filt(st_reg.dn_s, st_reg.dn_f);

    st_next.ref_tick = (st_reg.ref_cnt == REF_LAST);
    st_next.ref_cnt = st_next.ref_tick ? 4'h0 : st_reg.ref_cnt + 4'h1;

    if (i_wr) begin
      case (i_addr)
        `SCL_OFF_RX_WORD: begin
          st_next.rx_word = i_wdata[21:0];
          ev[`SCL_IRQ_DIV_BAD] = div_bad(i_wdata);
        end
        `SCL_OFF_TX_WORD: begin
          st_next.tx_word = i_wdata[21:0];
          ev[`SCL_IRQ_DIV_BAD] = div_bad(i_wdata);
        end
        `SCL_OFF_AUX_WORD: st_next.aux_word = i_wdata[21:0];
        `SCL_OFF_IRQ_EN: st_next.irq_en = i_wdata[2:0];
        default: ;
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        `SCL_OFF_RX_WORD: st_next.rdata = {10'h000, st_reg.rx_word};
        `SCL_OFF_TX_WORD: st_next.rdata = {10'h000, st_reg.tx_word};
        `SCL_OFF_AUX_WORD: st_next.rdata = {10'h000, st_reg.aux_word};
        `SCL_OFF_STATUS: st_next.rdata = {28'h0000000, i_tx_mode,
            st_reg.mod_sel, st_reg.amp_gain, st_reg.lock};
        `SCL_OFF_IRQ_STAT: st_next.rdata = {29'h0, st_reg.irq_stat};
        `SCL_OFF_IRQ_EN: st_next.rdata = {29'h0, st_reg.irq_en};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    ev[`SCL_IRQ_LOCK_RISE] = lk.lock_rise;
    ev[`SCL_IRQ_LOCK_FALL] = lk.lock_fall;
    // A new event beats a clear landing in the same cycle.
    if (i_wr && (i_addr == `SCL_OFF_IRQ_CLR)) begin
      st_next.irq_stat = st_reg.irq_stat & ~i_wdata[2:0];
    end
    st_next.irq_stat = st_next.irq_stat | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);

    st_next.div_out = i_tx_mode
        ? st_reg.tx_word[`SCL_DIV_MSB:`SCL_DIV_LSB]
        : st_reg.rx_word[`SCL_DIV_MSB:`SCL_DIV_LSB];
    st_next.band = st_reg.rx_word[`SCL_BAND_BIT];
    st_next.osc_cur = st_reg.rx_word[`SCL_OSC_CUR_LSB +: 2];
    st_next.pd_pol = st_reg.rx_word[`SCL_PD_POL_BIT];
    st_next.amp_gain = st_reg.rx_word[`SCL_GAIN_SRC_BIT]
        ? st_reg.aux_word[`SCL_INT_GAIN_BIT] : st_reg.gain_f;
    st_next.mod_sel = st_reg.tx_word[`SCL_MOD_SRC_BIT]
        ? st_reg.aux_word[`SCL_INT_MOD_BIT] : st_reg.mod_f;
    st_next.lock = lk.locked;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.rx_word <= `SCL_RX_WORD_RST;
      st_reg.tx_word <= `SCL_TX_WORD_RST;
      st_reg.aux_word <= `SCL_AUX_WORD_RST;
      st_reg.div_out <= `SCL_DIV_MIN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_feedback_divider = st_reg.div_out;
  assign o_band_select = st_reg.band;
  assign o_osc_current = st_reg.osc_cur;
  assign o_pd_polarity = st_reg.pd_pol;
  assign o_amp_gain = st_reg.amp_gain;
  assign o_modulation_sel = st_reg.mod_sel;
  assign o_lock = st_reg.lock;
  assign o_irq = st_reg.irq;
endmodule : scl_synth_cfg

/* File: verification/scl_synth_cfg_assertions.sv */
`timescale 1ns/1ns
module scl_synth_cfg_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_tx_mode,
  input wire logic i_ext_amp_gain_pin,
  input wire logic i_pd_up,
  input wire logic i_pd_down,
  input wire logic [16:0] o_feedback_divider,
  input wire logic o_band_select,
  input wire logic [1:0] o_osc_current,
  input wire logic o_pd_polarity,
  input wire logic o_amp_gain,
  input wire logic o_lock
);
  logic [7:0] err_reg;
  logic rx_w;
  assign rx_w = i_wr && i_addr == 8'h00;
  // Saturates so that a long slip never wraps back to a small count.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) err_reg <= 8'h00;
    else if (!(i_pd_up || i_pd_down)) err_reg <= 8'h00;
    else if (err_reg != 8'hFF) err_reg <= err_reg + 8'h01;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RX_DIV: assert property (rx_w ##1 !i_tx_mode && !i_wr
    |-> ##1 o_feedback_divider == $past(i_wdata[16:0], 2))
    else $error("rx divider");
  AST_TX_DIV: assert property (i_wr && i_addr == 8'h04 ##1 i_tx_mode
    && !i_wr |-> ##1 o_feedback_divider == $past(i_wdata[16:0], 2))
    else $error("tx divider");
  AST_BAND: assert property (rx_w |-> ##2
    o_band_select == $past(i_wdata[17], 2)) else $error("band");
  AST_OSC_CUR: assert property (rx_w |-> ##2
    o_osc_current == $past(i_wdata[19:18], 2)) else $error("osc");
  AST_PD_POL: assert property (rx_w |-> ##2
    o_pd_polarity == $past(i_wdata[20], 2)) else $error("polarity");
  AST_GAIN_PIN: assert property (rx_w && !i_wdata[21] ##1
    (!rx_w && $stable(i_ext_amp_gain_pin))[*8] |->
    o_amp_gain == i_ext_amp_gain_pin) else $error("gain pin");
  AST_LOCK_CLEAN: assert property ($rose(o_lock) |->
    !$past(i_pd_up, 10) && !$past(i_pd_down, 10)) else $error("lock");
  AST_UNLOCK: assert property (err_reg == 8'hC8 |-> !o_lock)
    else $error("unlock");
endmodule : scl_synth_cfg_chk
bind scl_synth_cfg scl_synth_cfg_chk scl_synth_cfg_chk_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_tx_mode(i_tx_mode),
  .i_ext_amp_gain_pin(i_ext_amp_gain_pin), .i_pd_up(i_pd_up),
  .i_pd_down(i_pd_down), .o_feedback_divider(o_feedback_divider),
  .o_band_select(o_band_select), .o_osc_current(o_osc_current),
  .o_pd_polarity(o_pd_polarity), .o_amp_gain(o_amp_gain),
  .o_lock(o_lock));

/* File: verification/scl_pll_model.sv */
`timescale 1ns/1ns
module scl_pll_model (
  input wire logic i_clk,
  input wire logic i_err,
  output logic o_pd_up,
  output logic o_pd_down
);
  logic [4:0] ph_reg = 5'h00;
  // Plain always: the phase counter has no reset and starts from its
  // declaration value, which an always_ff may not share with another driver.
  always @(posedge i_clk) begin
    ph_reg <= ph_reg + 5'h01;
  end
  // A slipping loop pumps one way, then the other, never idle between.
  assign o_pd_up = i_err & ~ph_reg[4];
  assign o_pd_down = i_err & ph_reg[4];
endmodule : scl_pll_model

/* File: verification/scl_synth_cfg_test.sv */
`timescale 1ns/1ns
module scl_synth_cfg_test;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    n_fail++; $display("mismatch %0t %h %h", $time, a, b); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_mode = 1'b0;
  logic err = 1'b0;
  logic gain = 1'b0;
  logic mod = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [16:0] div;
  logic [1:0] osc;
  logic band, pol, amp, msel, lock, irq, pu, pd;
  logic [15:0] lf = 16'hC0E2;
  int n_fail = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  scl_synth_cfg scl_synth_cfg_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_mode(tx_mode),
    .i_ext_amp_gain_pin(gain), .i_ext_mod_sel_pin(mod), .i_pd_up(pu),
    .i_pd_down(pd), .o_feedback_divider(div), .o_band_select(band),
    .o_osc_current(osc), .o_pd_polarity(pol), .o_amp_gain(amp),
    .o_modulation_sel(msel), .o_lock(lock), .o_irq(irq));
  scl_pll_model scl_pll_model_inst (.i_clk(clk), .i_err(err),
    .o_pd_up(pu), .o_pd_down(pd));
  function automatic logic [15:0] nx();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : nx
  function automatic int lim(input int base, input int sh);
    return (base << sh) * 10;
  endfunction : lim
  function automatic logic pick(input logic s, input logic a, input logic b);
    return s ? a : b;
  endfunction : pick
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (lock !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lvl
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    logic [21:0] rx, tx, ax;
    int n;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(div, 17'h00040)
    rd_chk(8'h04, 32'h40);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rx = 22'({nx(), nx()});
      tx = 22'({nx(), nx()});
      ax = 22'({nx(), nx()});
      rx[6] = 1'b1;
      tx[6] = 1'b1;
      if (i < 2) rx[16:0] = i ? 17'h00040 : 17'h1FFFF;
      @(posedge clk);
      gain <= ax[1];
      mod <= ax[2];
      tx_mode <= ax[0];
      wr_reg(8'h00, {10'h0, rx});
      wr_reg(8'h04, {10'h0, tx});
      wr_reg(8'h08, {10'h0, ax});
      repeat (8) @(negedge clk);
      `CHK(div, ax[0] ? tx[16:0] : rx[16:0])
      `CHK({pol, osc, band}, rx[20:17])
      `CHK(amp, pick(rx[21], ax[12], gain))
      `CHK(msel, pick(tx[21], ax[19], mod))
      rd_chk(8'h00, {10'h0, rx});
    end
    wr_reg(8'h18, 32'h3);
    for (int c = 0; c < 4; c++) begin
      err <= 1'b1;
      wr_reg(8'h04, {11'h0, c[1:0], c[1:0], 17'h00040});
      repeat (200) @(negedge clk);
      `CHK(lock, 1'b0)
      wr_reg(8'h14, 32'h7);
      err <= 1'b0;
      wait_lvl(1'b1, n);
      `CHK(n > lim(4, 2 * c) - 11 && n < lim(4, 2 * c) + 21, 1'b1)
      rd_chk(8'h0C, {28'h0, tx_mode, mod, pick(rx[21], ax[12], gain), 1'b1});
      err <= 1'b1;
      wait_lvl(1'b0, n);
      `CHK(n > lim(2, c) - 11 && n < lim(2, c) + 21, 1'b1)
      `CHK(irq, 1'b1)
      rd_chk(8'h10, 32'h3);
    end
    wr_reg(8'h14, 32'h7);
    wr_reg(8'h18, 32'h0);
    wr_reg(8'h00, 32'h3F);
    rd_chk(8'h10, 32'h4);
    `CHK(irq, 1'b0)
    wr_reg(8'h18, 32'h4);
    rd_chk(8'h18, 32'h4);
    `CHK(irq, 1'b1)
    wr_reg(8'h14, 32'h4);
    rd_chk(8'h10, 32'h0);
    `CHK(irq, 1'b0)
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule : scl_synth_cfg_test
